// >>> hw/wdtec_top.sv
// Watchdog enable control, time-out select and counter behind an APB slave
`timescale 1ns/1ns
`default_nettype none

module wdtec_top #(
    parameter int unsigned OSC_DIV_P    = wdtec_pkg::OSC_DIV,
    parameter int unsigned BASE_TICKS_P = wdtec_pkg::BASE_TICKS
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [wdtec_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         safety_level_fuse,
    output logic                              irq,
    output logic                              wdt_reset_req,
    output logic                              wdt_running
);
    import wdtec_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Reserved codes use the longest valid setting
    function automatic logic [TSEL_W-1:0] tsel_fix(input logic [TSEL_W-1:0] code);
        return (code > TSEL_W'(TSEL_MAX)) ? TSEL_W'(TSEL_MAX) : code;
    endfunction

    function automatic logic [CNT_W-1:0] tsel_limit(input logic [TSEL_W-1:0] code);
        return CNT_W'(BASE_TICKS_P) << tsel_fix(code);
    endfunction

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        return (a == OFF_CTRL) || (a == OFF_CAUSE) || (a == OFF_STAT)
            || (a == OFF_MASK) || (a == OFF_KICK) || (a == OFF_COUNT);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    localparam wdtec_state_s STATE_RST = '0;

    wdtec_state_s q;
    wdtec_state_s d;

    logic                acc_wr;
    logic                setup_rd;
    logic                tick;
    logic                unlocked;
    logic                en_eff;
    logic                running;
    logic                kick;
    logic                expire;
    logic [CNT_W-1:0]    limit;
    logic [EV_W-1:0]     ev;
    logic [EV_W-1:0]     stat_clr;
    logic [7:0]          ctrl_rd;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d        = q;
        ev       = '0;
        stat_clr = '0;

        // Zero wait states: every access phase completes at once
        acc_wr   = psel && penable && pwrite && addr_mapped(paddr);
        setup_rd = psel && !penable && !pwrite;

        // Fuse synchroniser; level moves only once two stages agree
        d.fuse_s1 = safety_level_fuse;
        d.fuse_s2 = q.fuse_s1;
        d.fuse_s3 = q.fuse_s2;
        if (q.fuse_s2 == q.fuse_s3) begin
            d.level = wdtec_level_e'(q.fuse_s3);
        end

        // Oscillator tick from the system clock
        tick = (q.div_cnt == DIV_W'(OSC_DIV_P - 1));
        if (tick) begin
            d.div_cnt = '0;
        end else begin
            d.div_cnt = q.div_cnt + 1'b1;
        end

        // Unlock window counts down on its own
        unlocked = (q.unlock_cnt != '0);
        if (unlocked) begin
            d.unlock_cnt = q.unlock_cnt - 1'b1;
        end

        kick = acc_wr && (paddr == OFF_KICK);

        ////////////////////////////////////////////////////////////////////////
        // Control register write
        if (acc_wr && (paddr == OFF_CTRL)) begin
            if (pwdata[EN_BIT]) begin
                d.en = 1'b1;
            end else if (unlocked && (q.level == WDTEC_LVL1)) begin
                d.en = 1'b0;
            end
            // The interrupt enable lands even when the clear is refused
            d.ie = pwdata[IE_BIT];
            // Level 2 guards the time-out behind the same window
            if ((q.level == WDTEC_LVL1) || unlocked) begin
                // Stored clamped so software reads back the code in use
                d.tsel = tsel_fix({pwdata[TSEL3_BIT], pwdata[TSEL_LO_W-1:0]});
            end
            // Arming needs both bits in one write
            if (pwdata[UNLOCK_BIT] && pwdata[EN_BIT]) begin
                d.unlock_cnt = UNLOCK_W'(UNLOCK_CYC);
            end else if (unlocked) begin
                // The closing write uses up the window
                d.unlock_cnt = '0;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Other register writes
        if (acc_wr && (paddr == OFF_CAUSE) && !pwdata[CAUSE_BIT]) begin
            d.cause = 1'b0;
        end
        if (acc_wr && (paddr == OFF_STAT)) begin
            stat_clr = pwdata[EV_W-1:0];
        end
        if (acc_wr && (paddr == OFF_MASK)) begin
            d.mask = pwdata[EV_W-1:0];
        end

        ////////////////////////////////////////////////////////////////////////
        // Counter and time-out
        en_eff  = q.en || (q.level == WDTEC_LVL2);
        running = en_eff || q.ie;
        limit   = tsel_limit(q.tsel);
        expire  = running && tick && !kick && (q.wd_cnt >= limit - 1'b1);
        d.rst_req = 1'b0;

        if (!running || kick) begin
            d.wd_cnt = '0;
        end else if (tick) begin
            if (expire) begin
                d.wd_cnt = '0;
            end else begin
                d.wd_cnt = q.wd_cnt + 1'b1;
            end
        end

        if (expire) begin
            if (q.ie) begin
                ev[EV_TIMEOUT] = 1'b1;
                // With the enable set, next expiry resets unless software re-arms the interrupt
                if (en_eff) begin
                    d.ie = 1'b0;
                end
            end else begin
                d.rst_req     = 1'b1;
                ev[EV_WDRST]  = 1'b1;
                d.cause       = 1'b1;
            end
        end

        // Flag overrides any write to the enable
        if ((q.level == WDTEC_LVL1) && q.cause) begin
            d.en = 1'b1;
        end
        if (q.level == WDTEC_LVL2) begin
            d.en = 1'b1;
        end

        // Sticky status: a set in the clearing cycle wins
        d.stat = (q.stat & ~stat_clr) | ev;

        ////////////////////////////////////////////////////////////////////////
        // Read data, captured in the setup phase
        ctrl_rd = '0;
        ctrl_rd[IE_BIT]            = q.ie;
        ctrl_rd[TSEL3_BIT]         = q.tsel[TSEL_W-1];
        ctrl_rd[UNLOCK_BIT]        = unlocked;
        ctrl_rd[EN_BIT]            = en_eff;
        ctrl_rd[TSEL_LO_W-1:0]     = q.tsel[TSEL_LO_W-1:0];

        if (setup_rd) begin
            d.rdata = '0;
            unique case (paddr)
                OFF_CTRL: begin
                    d.rdata[7:0] = ctrl_rd;
                end
                OFF_CAUSE: begin
                    d.rdata[CAUSE_BIT] = q.cause;
                end
                OFF_STAT: begin
                    d.rdata[EV_W-1:0] = q.stat;
                end
                OFF_MASK: begin
                    d.rdata[EV_W-1:0] = q.mask;
                end
                OFF_COUNT: begin
                    d.rdata[CNT_W-1:0] = q.wd_cnt;
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata        = q.rdata;
    assign pready        = 1'b1;
    // Unmapped addresses answer with an error and change nothing
    assign pslverr       = psel && penable && !addr_mapped(paddr);
    assign irq           = |(q.stat & q.mask);
    // Pulse goes to the system reset logic; it must not drive presetn,
    // or the cause flag would be lost with it
    assign wdt_reset_req = q.rst_req;
    assign wdt_running   = (q.en || (q.level == WDTEC_LVL2)) || q.ie;

endmodule

`default_nettype wire

// >>> hw/wdtec_pkg.sv
// Constants, register map and state record of the watchdog enable/time-out block
package wdtec_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and oscillator rates
    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam int unsigned OSC_HZ      = 128_000;
    // Closest whole divider; the tick runs slightly fast of the true rate
    localparam int unsigned OSC_DIV     = CLK_HZ / OSC_HZ;
    localparam int unsigned DIV_W       = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Timing counts
    localparam int unsigned UNLOCK_CYC  = 4;
    localparam int unsigned UNLOCK_W    = 3;
    localparam int unsigned BASE_TICKS  = 2048;
    localparam int unsigned TSEL_MAX    = 9;
    localparam int unsigned TSEL_W      = 4;
    localparam int unsigned CNT_W       = 21;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam int unsigned ADDR_W      = 8;
    localparam logic [7:0]  OFF_CTRL    = 8'h00;
    localparam logic [7:0]  OFF_CAUSE   = 8'h04;
    localparam logic [7:0]  OFF_STAT    = 8'h08;
    localparam logic [7:0]  OFF_MASK    = 8'h0c;
    localparam logic [7:0]  OFF_KICK    = 8'h10;
    localparam logic [7:0]  OFF_COUNT   = 8'h14;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned IE_BIT      = 6;
    localparam int unsigned TSEL3_BIT   = 5;
    localparam int unsigned UNLOCK_BIT  = 4;
    localparam int unsigned EN_BIT      = 3;
    localparam int unsigned TSEL_LO_W   = 3;
    localparam int unsigned CAUSE_BIT   = 3;
    localparam int unsigned EV_TIMEOUT  = 0;
    localparam int unsigned EV_WDRST    = 1;
    localparam int unsigned EV_W        = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic {
        WDTEC_LVL1 = 1'b0,
        WDTEC_LVL2 = 1'b1
    } wdtec_level_e;

    typedef struct packed {
        logic                fuse_s1;
        logic                fuse_s2;
        logic                fuse_s3;
        wdtec_level_e        level;
        logic [DIV_W-1:0]    div_cnt;
        logic [CNT_W-1:0]    wd_cnt;
        logic                en;
        logic                ie;
        logic [TSEL_W-1:0]   tsel;
        logic [UNLOCK_W-1:0] unlock_cnt;
        logic                cause;
        logic [EV_W-1:0]     stat;
        logic [EV_W-1:0]     mask;
        logic [31:0]         rdata;
        logic                rst_req;
    } wdtec_state_s;

endpackage

// >>> test/wdtec_checker.sv
// Port-level assertions for the watchdog enable/time-out block
`timescale 1ns/1ns
`default_nettype none
module wdtec_checker (
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [wdtec_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                  pwdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    input wire logic                         safety_level_fuse,
    input wire logic                         irq,
    input wire logic                         wdt_reset_req,
    input wire logic                         wdt_running
);
    import wdtec_pkg::*;
    logic       wr_ctrl;
    logic       mapped;
    logic       en_q;
    logic [2:0] arm_q;
    logic [2:0] fuse_q;
    assign wr_ctrl = psel && penable && pwrite && (paddr == OFF_CTRL);
    assign mapped = paddr inside {OFF_CTRL, OFF_CAUSE, OFF_STAT, OFF_MASK, OFF_KICK, OFF_COUNT};
    // Enable tracked only from writes; unknown cases leave en_q low, the safe side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_q <= 3'h0;
            en_q <= 1'b0;
            fuse_q <= 3'h0;
        end else begin
            if (wr_ctrl) begin
                arm_q <= (pwdata[4] && pwdata[3]) ? 3'h4 : 3'h0;
                en_q <= pwdata[3] || (en_q && arm_q == 3'h0);
            end else if (arm_q != 3'h0) begin
                arm_q <= arm_q - 3'h1;
            end
            fuse_q <= !safety_level_fuse ? 3'h0 : (fuse_q == 3'h7) ? fuse_q : fuse_q + 3'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_always_a: assert property (pready) else $error("pready low");
    slverr_map_a: assert property (pslverr == (psel && penable && !mapped)) else $error("pslverr");
    reset_quiet_a: assert property ($rose(presetn) |-> !irq && !wdt_running) else $error("rst");
    enable_start_a: assert property (wr_ctrl && pwdata[3] |=> wdt_running) else $error("en");
    clear_refused_a: assert property (wr_ctrl && !pwdata[3] && arm_q == 3'h0 && en_q
        |=> wdt_running) else $error("clear taken without unlock");
    level_two_a: assert property (fuse_q == 3'h7 |-> wdt_running) else $error("lvl2 stop");
    req_pulse_a: assert property (wdt_reset_req |=> !wdt_reset_req) else $error("req");
    req_running_a: assert property (wdt_reset_req |-> wdt_running) else $error("req idle");
    irq_cause_a: assert property ($rose(irq) |-> $past(wdt_running) || $past(psel && pwrite))
        else $error("irq without cause");
    cover property (wdt_reset_req);
    cover property ($rose(irq));
    cover property (wr_ctrl && arm_q != 3'h0);
endmodule
`default_nettype wire

// >>> test/wdtec_top_tb.sv
// Self-checking bench for the watchdog enable/time-out block
`timescale 1ns/1ns
`default_nettype none
module wdtec_top_tb;
    import wdtec_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        fuse = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, pslverr, irq, wdt_reset_req, wdt_running;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          n;
    always #25 pclk = ~pclk;
    // Short divider and base count give time-outs of 8 cycles at code 0 up to 4096 cycles at code 9
    wdtec_top #(.OSC_DIV_P(2), .BASE_TICKS_P(4)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .safety_level_fuse(fuse),
        .irq(irq), .wdt_reset_req(wdt_reset_req), .wdt_running(wdt_running));
    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset(input logic f);
        presetn <= 1'b0;
        fuse <= f;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_basic;
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h2c);
        @(negedge pclk);
        chk(wdt_running, 32'h1);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd, 32'h29);
    endtask
    task automatic t_unlock;
        // Long time-out kept so no expiry sets the cause flag here
        apb(1'b1, OFF_CTRL, 32'h07);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd, 32'h0f);
        apb(1'b1, OFF_CTRL, 32'h17);
        apb(1'b1, OFF_CTRL, 32'h07);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd, 32'h0f);
        apb(1'b1, OFF_CTRL, 32'h1f);
        repeat (6) @(posedge pclk);
        apb(1'b1, OFF_CTRL, 32'h07);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd, 32'h0f);
        apb(1'b1, OFF_CTRL, 32'h1f);
        apb(1'b1, OFF_CTRL, 32'h07);
        @(negedge pclk);
        chk(wdt_running, 32'h0);
    endtask
    task automatic t_irq;
        apb(1'b1, OFF_MASK, 32'h1);
        apb(1'b1, OFF_CTRL, 32'h41);
        n = 0;
        while (irq !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        // Eight ticks of two cycles each, plus divider phase
        chk(32'(n >= 12 && n <= 20), 32'h1);
        apb(1'b1, OFF_MASK, 32'h0);
        @(negedge pclk);
        chk(irq, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h0);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(rd[0], 32'h1);
        apb(1'b1, OFF_STAT, 32'h1);
        apb(1'b1, OFF_MASK, 32'h1);
        @(negedge pclk);
        chk(irq, 32'h0);
        chk(wdt_running, 32'h0);
    endtask
    task automatic t_rstmode;
        apb(1'b1, OFF_CTRL, 32'h0b);
        n = 0;
        while (wdt_reset_req !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n < 300), 32'h1);
        apb(1'b0, OFF_CAUSE, 32'h0);
        chk(rd[3], 32'h1);
        apb(1'b1, OFF_CTRL, 32'h1b);
        apb(1'b1, OFF_CTRL, 32'h03);
        @(negedge pclk);
        chk(wdt_running, 32'h1);
        apb(1'b1, OFF_KICK, 32'h0);
        apb(1'b1, OFF_CAUSE, 32'h0);
        apb(1'b0, OFF_CAUSE, 32'h0);
        chk(rd[3], 32'h0);
        apb(1'b1, OFF_CTRL, 32'h1b);
        apb(1'b1, OFF_CTRL, 32'h03);
        @(negedge pclk);
        chk(wdt_running, 32'h0);
    endtask
    task automatic t_lvl2;
        do_reset(1'b1);
        repeat (6) @(posedge pclk);
        @(negedge pclk);
        chk(wdt_running, 32'h1);
        apb(1'b1, OFF_CTRL, 32'h18);
        apb(1'b1, OFF_CTRL, 32'h0);
        @(negedge pclk);
        chk(wdt_running, 32'h1);
    endtask
    initial begin
        do_reset(1'b0);
        t_basic();
        t_unlock();
        t_irq();
        t_rstmode();
        t_lvl2();
        print_verdict();
    end
    initial begin
        repeat (4000) @(posedge pclk);
        num_errors++;
        print_verdict();
    end
endmodule
bind wdtec_top wdtec_checker CHK (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .safety_level_fuse(safety_level_fuse), .irq(irq),
    .wdt_reset_req(wdt_reset_req), .wdt_running(wdt_running));
`default_nettype wire
